// File: common/sacc_defs.vh
// constants for the sar converter control block
// assumes a 32-bit apb slave and a 10-bit sar analog core
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// register byte offsets
`define SACC_OFF_CTRL_A   8'h00
`define SACC_OFF_CTRL_B   8'h04
`define SACC_OFF_CTRL_C   8'h08
`define SACC_OFF_RES_HI   8'h0c
`define SACC_OFF_RES_LO   8'h10
`define SACC_OFF_STATUS   8'h14

// control a fields
`define SACC_ON_BIT       0
`define SACC_GO_BIT       1
`define SACC_CHAN_LSB     2
`define SACC_CHAN_MSB     5
// control b fields
`define SACC_PCFG_LSB     0
`define SACC_PCFG_MSB     3
`define SACC_VRP_BIT      4
`define SACC_VRM_BIT      5
// control c fields
`define SACC_CCS_LSB      0
`define SACC_CCS_MSB      2
`define SACC_ACQ_LSB      3
`define SACC_ACQ_MSB      5
`define SACC_FMT_BIT      7
// status fields
`define SACC_DONE_BIT     0

// reset values
`define SACC_RST_CTRL_A   6'h00
`define SACC_RST_CTRL_B   6'h00
`define SACC_RST_CTRL_C   8'h00

// conversion clock divisors minus one
`define SACC_DIV2         6'h01
`define SACC_DIV4         6'h03
`define SACC_DIV8         6'h07
`define SACC_DIV16        6'h0f
`define SACC_DIV32        6'h1f
`define SACC_DIV64        6'h3f
`define SACC_CCS_RC_LOW   2'h3

// acquisition lengths in bit periods
`define SACC_ACQ_MANUAL   3'h0
`define SACC_ACQ_2        5'h02
`define SACC_ACQ_4        5'h04
`define SACC_ACQ_6        5'h06
`define SACC_ACQ_8        5'h08
`define SACC_ACQ_12       5'h0c
`define SACC_ACQ_16       5'h10
`define SACC_ACQ_20       5'h14

// sequence lengths in bit periods
`define SACC_CONV_TADS    4'hb
`define SACC_RECOV_TADS   2'h3
// first trial code of each conversion
`define SACC_SAR_MID      10'h200

// analog pin count and pin configuration knee
`define SACC_NPINS        5'h0d
`define SACC_PCFG_KNEE    4'h3
`define SACC_PCFG_BASE    5'h0f

`endif

// File: rtl/sacc_top.v
// sar converter control: apb registers, bit-period timing, sequencing
// assumes comparator and rc oscillator inputs are asynchronous pins
`timescale 1ns/1ps
`include "sacc_defs.vh"

module sacc_top (
    // clock and reset
    input  wire        clk_sys,
    input  wire        resetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // analog core
    input  wire        comp_in,
    input  wire        rc_clk_in,
    output wire [9:0]  dac_code,
    output wire        sample_en,
    output wire [3:0]  chan_sel,
    output wire        vref_plus_ext,
    output wire        vref_minus_ext,
    output wire [12:0] pin_analog
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ACQ  = 4'b0010;
    localparam [3:0] ST_CONV = 4'b0100;
    localparam [3:0] ST_REC  = 4'b1000;

    reg  [3:0]  state_r;
    reg  [3:0]  state_nxt;
    reg  [5:0]  ctrl_a_r;
    reg  [5:0]  ctrl_b_r;
    reg  [7:0]  ctrl_c_r;
    reg  [7:0]  res_hi_r;
    reg  [7:0]  res_lo_r;
    reg         done_flag_r;
    reg  [31:0] prdata_r;
    reg  [5:0]  div_cnt_r;
    reg  [4:0]  seq_cnt_r;
    reg  [4:0]  seq_cnt_nxt;
    reg  [9:0]  sar_r;
    reg  [9:0]  sar_nxt;
    reg         comp_s1_r;
    reg         comp_s2_r;
    reg         rc_s1_r;
    reg         rc_s2_r;
    reg         rc_s3_r;
    reg  [5:0]  div_max;
    reg  [4:0]  acq_len;
    reg  [31:0] rd_mux;
    reg         hit;
    reg  [12:0] pin_an;
    reg  [4:0]  an_count;
    reg         go_clr;
    reg         load_res;
    integer     i;
    integer     k;

    wire        wr_en = psel & penable & pwrite;
    wire        rd_setup = psel & ~penable;
    wire        conv_on = ctrl_a_r[`SACC_ON_BIT];
    wire        go_busy = ctrl_a_r[`SACC_GO_BIT];
    wire [2:0]  ccs = ctrl_c_r[`SACC_CCS_MSB:`SACC_CCS_LSB];
    wire [2:0]  acq_sel = ctrl_c_r[`SACC_ACQ_MSB:`SACC_ACQ_LSB];
    wire        use_rc = (ccs[1:0] == `SACC_CCS_RC_LOW);
    wire        rc_edge = rc_s2_r & ~rc_s3_r;
    wire        tad_tick = use_rc ? rc_edge : (div_cnt_r == div_max);
    wire        timing = (state_r != ST_IDLE);
    wire [9:0]  res_val = sar_nxt;

    // apb answers at once, decode errors flagged
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_r;

    // analog core outputs
    assign dac_code       = sar_r;
    assign chan_sel       = ctrl_a_r[`SACC_CHAN_MSB:`SACC_CHAN_LSB];
    assign vref_plus_ext  = ctrl_b_r[`SACC_VRP_BIT];
    assign vref_minus_ext = ctrl_b_r[`SACC_VRM_BIT];
    assign sample_en      = conv_on & ((state_r == ST_IDLE) | (state_r == ST_ACQ));
    assign pin_analog     = pin_an;

    // address decode and read mux
    always @* begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == `SACC_OFF_CTRL_A) begin
            rd_mux[5:0] = ctrl_a_r;
        end else if (paddr == `SACC_OFF_CTRL_B) begin
            rd_mux[5:0] = ctrl_b_r;
        end else if (paddr == `SACC_OFF_CTRL_C) begin
            rd_mux[7:0] = ctrl_c_r;
        end else if (paddr == `SACC_OFF_RES_HI) begin
            rd_mux[7:0] = res_hi_r;
        end else if (paddr == `SACC_OFF_RES_LO) begin
            rd_mux[7:0] = res_lo_r;
        end else if (paddr == `SACC_OFF_STATUS) begin
            rd_mux[`SACC_DONE_BIT] = done_flag_r;
        end else begin
            hit = 1'b0;
        end
    end

    // pin configuration decode
    always @* begin
        if (ctrl_b_r[`SACC_PCFG_MSB:`SACC_PCFG_LSB] < `SACC_PCFG_KNEE)
            an_count = `SACC_NPINS;
        else
            an_count = `SACC_PCFG_BASE - {1'b0, ctrl_b_r[`SACC_PCFG_MSB:`SACC_PCFG_LSB]};
        for (i = 0; i < `SACC_NPINS; i = i + 1)
            pin_an[i] = (i < an_count);
    end

    // conversion clock divisor
    always @* begin
        case (ccs)
            3'h0:    div_max = `SACC_DIV2;
            3'h1:    div_max = `SACC_DIV8;
            3'h2:    div_max = `SACC_DIV32;
            3'h4:    div_max = `SACC_DIV4;
            3'h5:    div_max = `SACC_DIV16;
            3'h6:    div_max = `SACC_DIV64;
            default: div_max = `SACC_DIV2;
        endcase
    end

    // acquisition length
    always @* begin
        case (acq_sel)
            3'h1:    acq_len = `SACC_ACQ_2;
            3'h2:    acq_len = `SACC_ACQ_4;
            3'h3:    acq_len = `SACC_ACQ_6;
            3'h4:    acq_len = `SACC_ACQ_8;
            3'h5:    acq_len = `SACC_ACQ_12;
            3'h6:    acq_len = `SACC_ACQ_16;
            3'h7:    acq_len = `SACC_ACQ_20;
            default: acq_len = 5'h00;
        endcase
    end

    // sequencer
    always @* begin
        state_nxt   = state_r;
        seq_cnt_nxt = seq_cnt_r;
        sar_nxt     = sar_r;
        go_clr      = 1'b0;
        load_res    = 1'b0;
        case (state_r)
            ST_IDLE: begin
                seq_cnt_nxt = 5'h00;
                if (conv_on & go_busy) begin
                    if (acq_sel == `SACC_ACQ_MANUAL) begin
                        state_nxt = ST_CONV;
                    end else begin
                        state_nxt   = ST_ACQ;
                        seq_cnt_nxt = acq_len;
                    end
                end
            end
            ST_ACQ: begin
                if (~go_busy | ~conv_on) begin
                    state_nxt   = ST_REC;
                    seq_cnt_nxt = 5'h00;
                end else if (tad_tick) begin
                    seq_cnt_nxt = seq_cnt_r - 5'h01;
                    if (seq_cnt_r == 5'h01) begin
                        state_nxt   = ST_CONV;
                        seq_cnt_nxt = 5'h00;
                    end
                end
            end
            ST_CONV: begin
                if (~go_busy | ~conv_on) begin
                    state_nxt   = ST_REC;
                    seq_cnt_nxt = 5'h00;
                end else if (tad_tick) begin
                    seq_cnt_nxt = seq_cnt_r + 5'h01;
                    if (seq_cnt_r == 5'h00) begin
                        sar_nxt = `SACC_SAR_MID;
                    end else begin
                        // resolve current trial bit, then try the next
                        sar_nxt = sar_r;
                        for (k = 0; k < 10; k = k + 1) begin
                            if (k == 10 - seq_cnt_r) begin
                                sar_nxt[k] = comp_s2_r;
                                if (k > 0)
                                    sar_nxt[k-1] = 1'b1;
                            end
                        end
                    end
                    if (seq_cnt_r == {1'b0, `SACC_CONV_TADS} - 5'h01) begin
                        state_nxt   = ST_REC;
                        seq_cnt_nxt = 5'h00;
                        go_clr      = 1'b1;
                        load_res    = 1'b1;
                    end
                end
            end
            ST_REC: begin
                if (tad_tick) begin
                    seq_cnt_nxt = seq_cnt_r + 5'h01;
                    if (seq_cnt_r == {3'h0, `SACC_RECOV_TADS} - 5'h01)
                        state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt   = ST_IDLE;
                seq_cnt_nxt = 5'h00;
            end
        endcase
    end

    // synchronisers for analog-side inputs
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            comp_s1_r <= 1'b0;
            comp_s2_r <= 1'b0;
            rc_s1_r   <= 1'b0;
            rc_s2_r   <= 1'b0;
            rc_s3_r   <= 1'b0;
        end else begin
            comp_s1_r <= comp_in;
            comp_s2_r <= comp_s1_r;
            rc_s1_r   <= rc_clk_in;
            rc_s2_r   <= rc_s1_r;
            rc_s3_r   <= rc_s2_r;
        end
    end

    // control state, registers, apb read data
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ST_IDLE;
            ctrl_a_r    <= `SACC_RST_CTRL_A;
            ctrl_b_r    <= `SACC_RST_CTRL_B;
            ctrl_c_r    <= `SACC_RST_CTRL_C;
            done_flag_r <= 1'b0;
            prdata_r    <= 32'h0000_0000;
            div_cnt_r   <= 6'h00;
            seq_cnt_r   <= 5'h00;
            sar_r       <= 10'h000;
        end else begin
            state_r   <= state_nxt;
            seq_cnt_r <= seq_cnt_nxt;
            sar_r     <= sar_nxt;
            if (rd_setup)
                prdata_r <= rd_mux;
            if (!timing | tad_tick | use_rc)
                div_cnt_r <= 6'h00;
            else
                div_cnt_r <= div_cnt_r + 6'h01;
            if (wr_en && paddr == `SACC_OFF_CTRL_A) begin
                ctrl_a_r[`SACC_CHAN_MSB:`SACC_CHAN_LSB] <= pwdata[`SACC_CHAN_MSB:`SACC_CHAN_LSB];
                ctrl_a_r[`SACC_ON_BIT] <= pwdata[`SACC_ON_BIT];
                ctrl_a_r[`SACC_GO_BIT] <= pwdata[`SACC_GO_BIT] & conv_on;
            end else if (go_clr) begin
                ctrl_a_r[`SACC_GO_BIT] <= 1'b0;
            end
            if (wr_en && paddr == `SACC_OFF_CTRL_B)
                ctrl_b_r <= pwdata[`SACC_VRM_BIT:`SACC_PCFG_LSB];
            if (wr_en && paddr == `SACC_OFF_CTRL_C)
                ctrl_c_r <= {pwdata[`SACC_FMT_BIT], 1'b0, pwdata[`SACC_ACQ_MSB:`SACC_CCS_LSB]};
            if (load_res)
                done_flag_r <= 1'b1;
            else if (wr_en && paddr == `SACC_OFF_STATUS)
                done_flag_r <= pwdata[`SACC_DONE_BIT];
        end
    end

    // result pair has no reset
    always @(posedge clk_sys) begin
        if (load_res) begin
            if (ctrl_c_r[`SACC_FMT_BIT]) begin
                res_hi_r <= {6'h00, res_val[9:8]};
                res_lo_r <= res_val[7:0];
            end else begin
                res_hi_r <= res_val[9:2];
                res_lo_r <= {res_val[1:0], 6'h00};
            end
        end else begin
            if (wr_en && paddr == `SACC_OFF_RES_HI)
                res_hi_r <= pwdata[7:0];
            if (wr_en && paddr == `SACC_OFF_RES_LO)
                res_lo_r <= pwdata[7:0];
        end
    end

endmodule

// File: tb/sacc_analog.sv
// analog far side: channel levels, held sample, rc oscillator
// assumes comp_in goes through a synchroniser inside the block
`timescale 1ns/1ps
module sacc_analog (
    // core side
    input  wire         sample_en,
    input  wire [3:0]   chan_sel,
    input  wire [9:0]   dac_code,
    output wire         comp_in,
    output reg          rc_clk_in,
    // bench side
    input  wire [129:0] levels,
    input  wire         rc_run
);
    reg  [9:0]   held_r;
    initial rc_clk_in = 1'b0;
    // tracks the pin only while connected
    always @* if (sample_en) held_r = levels[chan_sel * 10 +: 10];
    assign comp_in = held_r >= dac_code;
    // stands still while not selected
    always #300 if (rc_run) rc_clk_in = ~rc_clk_in;
endmodule

// File: tb/sacc_props_properties.sv
// assertions on the sar control ports
// assumes a bind onto sacc_top; apb writes land at the access edge
`timescale 1ns/1ps
`include "sacc_defs.vh"
module sacc_props (
    // clock and reset
    input wire        clk_sys,
    input wire        resetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    // analog core
    input wire [9:0]  dac_code,
    input wire        sample_en,
    input wire        vref_plus_ext,
    input wire        vref_minus_ext,
    input wire [12:0] pin_analog
);
    reg        on_r;
    reg  [2:0] acq_r;
    wire       wr = psel & penable & pwrite;
    wire       wr_b = wr && paddr == `SACC_OFF_CTRL_B;
    wire       go = wr && paddr == `SACC_OFF_CTRL_A && pwdata[1:0] == 2'h3 && on_r && sample_en;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            on_r  <= 1'b0;
            acq_r <= 3'h0;
        end else if (wr && paddr == `SACC_OFF_CTRL_A) begin
            on_r <= pwdata[0];
        end else if (wr && paddr == `SACC_OFF_CTRL_C) begin
            acq_r <= pwdata[5:3];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    chk_ref_plus: assert property (wr_b |=> vref_plus_ext == $past(pwdata[4]))
        else $error("vref plus select wrong");
    chk_ref_minus: assert property (wr_b |=> vref_minus_ext == $past(pwdata[5]))
        else $error("vref minus select wrong");
    chk_pins_digital: assert property (wr_b && pwdata[3:0] == 4'hf |=> pin_analog == 13'h0)
        else $error("pins still analog");
    chk_manual_stop: assert property (go && acq_r == 3'h0 |-> ##[1:2] !sample_en)
        else $error("manual go kept sampling");
    chk_acq_hold: assert property (go && acq_r != 3'h0 |=> sample_en [*3])
        else $error("acquisition cut short");
    chk_first_trial: assert property (go && acq_r == 3'h0 |-> ##[1:80] dac_code == 10'h200)
        else $error("no midscale trial");
    chk_hold_open: assert property ($fell(sample_en) && on_r |-> !sample_en [*5])
        else $error("capacitor reconnected early");
    chk_off_quiet: assert property (!on_r && !$past(on_r) |-> !sample_en)
        else $error("sampling while off");
    cover property (go && acq_r == 3'h0);
    cover property (go && acq_r != 3'h0);
    cover property ($fell(sample_en) && on_r);
endmodule
bind sacc_top sacc_props chk_u (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .dac_code(dac_code), .sample_en(sample_en),
    .vref_plus_ext(vref_plus_ext), .vref_minus_ext(vref_minus_ext), .pin_analog(pin_analog));

// File: tb/tb.sv
// self-checking bench for the sar converter control block
// assumes sacc_top with its checker bind and the sacc_analog far side
`timescale 1ns/1ps
`include "sacc_defs.vh"
module tb;
    reg          clk_sys, resetn, psel, penable, pwrite, rc_run, se;
    reg  [7:0]   paddr;
    reg  [31:0]  pwdata, rd;
    reg  [129:0] levels;
    reg  [32:0]  r;
    reg  [32:0]  rows [0:9];
    wire [31:0]  prdata;
    wire         pready, pslverr, comp_in, rc_clk_in, sample_en, vref_plus_ext, vref_minus_ext;
    wire [9:0]   dac_code;
    wire [3:0]   chan_sel;
    wire [12:0]  pin_analog;
    integer      err_total, samples_checked, i, j, n, dv;
    time         t0;
    sacc_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .comp_in(comp_in),
        .rc_clk_in(rc_clk_in), .dac_code(dac_code), .sample_en(sample_en), .chan_sel(chan_sel),
        .vref_plus_ext(vref_plus_ext), .vref_minus_ext(vref_minus_ext), .pin_analog(pin_analog));
    sacc_analog ana_u (.sample_en(sample_en), .chan_sel(chan_sel), .dac_code(dac_code), .comp_in(comp_in),
        .rc_clk_in(rc_clk_in), .levels(levels), .rc_run(rc_run));
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1) @(posedge clk_sys);
            rd = prdata;
            se = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("mismatch at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task cmp_rng(input integer v, input integer lo, input integer hi);
        begin
            samples_checked = samples_checked + 1;
            if (v < lo || v > hi) begin
                err_total = err_total + 1;
                $display("mismatch at %0t: %0d cycles, want %0d..%0d", $time, v, lo, hi);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d); apb(1'b1, a, d); endtask
    task rdc(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            cmp(rd, exp);
        end
    endtask
    task stop_test;
        begin
            $display("checked %0d, mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        #2000000;
        err_total = err_total + 1;
        stop_test;
    end
    initial begin
        {resetn, psel, penable, pwrite, rc_run} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        levels = 130'h0;
        err_total = 0;
        samples_checked = 0;
        // clock sel, acq sel, channel, right justify, level, divisor (0 = rc), acq periods
        rows[0] = {3'h0, 3'h1, 4'h1, 1'b1, 10'h3ff, 7'h02, 5'h02};
        rows[1] = {3'h4, 3'h2, 4'h2, 1'b0, 10'h000, 7'h04, 5'h04};
        rows[2] = {3'h1, 3'h3, 4'h3, 1'b0, 10'h3ff, 7'h08, 5'h06};
        rows[3] = {3'h5, 3'h4, 4'h4, 1'b1, 10'h2a5, 7'h10, 5'h08};
        rows[4] = {3'h2, 3'h5, 4'hc, 1'b0, 10'h15a, 7'h20, 5'h0c};
        rows[5] = {3'h6, 3'h6, 4'h7, 1'b1, 10'h1c3, 7'h40, 5'h10};
        rows[6] = {3'h6, 3'h7, 4'h9, 1'b0, 10'h0e7, 7'h40, 5'h14};
        rows[7] = {3'h2, 3'h0, 4'h0, 1'b1, 10'h301, 7'h20, 5'h00};
        rows[8] = {3'h3, 3'h0, 4'h5, 1'b0, 10'h2c4, 7'h00, 5'h00};
        rows[9] = {3'h7, 3'h1, 4'hb, 1'b1, 10'h13b, 7'h00, 5'h00};
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        for (i = 0; i < 10; i = i + 1) begin
            r = rows[i];
            dv = r[11:5];
            rc_run <= (dv == 0);
            for (j = 0; j < 13; j = j + 1)
                levels[j * 10 +: 10] <= (j == r[26:23]) ? r[21:12] : ~r[21:12];
            wr(`SACC_OFF_CTRL_C, {24'h0, r[22], 1'b0, r[29:27], r[32:30]});
            wr(`SACC_OFF_CTRL_A, {26'h0, r[26:23], 2'h1});
            wr(`SACC_OFF_STATUS, 32'h0);
            wr(`SACC_OFF_CTRL_A, {26'h0, r[26:23], 2'h3});
            t0 = $time;
            apb(1'b0, `SACC_OFF_CTRL_A, 32'h0);
            cmp(rd[1], 1'b1);
            for (n = 0; n < 3000 && rd[1] === 1'b1; n = n + 1)
                apb(1'b0, `SACC_OFF_CTRL_A, 32'h0);
            cmp(rd[1], 1'b0);
            n = ($time - t0) / 40;
            if (dv != 0) cmp_rng(n, (r[4:0] + 11) * dv, (r[4:0] + 11) * dv + 8);
            t0 = $time;
            while (sample_en !== 1'b1 && $time - t0 < 100000) @(posedge clk_sys);
            if (dv != 0) cmp_rng(($time - t0) / 40, 3 * dv - 4, 3 * dv + 2);
            cmp(sample_en, 1'b1);
            rdc(`SACC_OFF_RES_HI, r[22] ? {30'h0, r[21:20]} : {24'h0, r[21:14]});
            rdc(`SACC_OFF_RES_LO, r[22] ? {24'h0, r[19:12]} : {24'h0, r[13:12], 6'h0});
            rdc(`SACC_OFF_STATUS, 32'h1);
            $display("row %0d done", i);
        end
        for (i = 0; i < 16; i = i + 1) begin
            wr(`SACC_OFF_CTRL_B, {26'h0, i[1:0], i[3:0]});
            @(posedge clk_sys);
            cmp({vref_minus_ext, vref_plus_ext}, i[1:0]);
            cmp(pin_analog, ((32'h1 << (15 - i)) - 1) & 32'h1fff);
        end
        $display("pin configuration done");
        apb(1'b0, 8'h18, 32'h0);
        cmp(rd, 32'h0);
        cmp(se, 1'b1);
        $display("unmapped read done");
        wr(`SACC_OFF_CTRL_A, 32'h0);
        wr(`SACC_OFF_CTRL_A, 32'h2);
        rdc(`SACC_OFF_CTRL_A, 32'h0);
        cmp(sample_en, 1'b0);
        wr(`SACC_OFF_CTRL_A, 32'h3);
        rdc(`SACC_OFF_CTRL_A, 32'h1);
        $display("go while off done");
        wr(`SACC_OFF_RES_HI, 32'h5a);
        wr(`SACC_OFF_CTRL_C, 32'h06);
        wr(`SACC_OFF_STATUS, 32'h0);
        wr(`SACC_OFF_CTRL_A, 32'h3);
        repeat (100) @(posedge clk_sys);
        wr(`SACC_OFF_CTRL_A, 32'h1);
        rdc(`SACC_OFF_CTRL_A, 32'h1);
        rdc(`SACC_OFF_RES_HI, 32'h5a);
        rdc(`SACC_OFF_STATUS, 32'h0);
        $display("abort done");
        wr(`SACC_OFF_CTRL_A, 32'h3);
        repeat (300) @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        cmp(sample_en, 1'b0);
        rdc(`SACC_OFF_CTRL_A, 32'h0);
        rdc(`SACC_OFF_CTRL_C, 32'h0);
        rdc(`SACC_OFF_RES_HI, 32'h5a);
        $display("reset done");
        stop_test;
    end
endmodule
